// [inc/txmfd_map.vh]
// Constants for the transmit mode field decoder
// Notes on behaviour
// - Bits 11-9 give gain, 1.5 dB steps
// - DTMF bits 7-5 select the twist value
// - Twist changes upper tone group only
// - New twist applies only when tone starts
// - Bits 8-7 select guard tone, high band
// - Bits 6-5 steer scrambler and detector
// - Bits 4-3 select the character format
// - Start-stop: data length and stop count
// - Synchronous: bits 2-0 pick data source
// - Tones, bit 4 clear: tone or pair
// - Bit 4 set: DTMF keypad pair
// - Resets clear and hold register at zero
// - Bits 15-12 select the transmit mode
`ifndef TXMFD_MAP_VH
`define TXMFD_MAP_VH

// ----------------------------------------------------------------
// Register layout
// ----------------------------------------------------------------
`define TXMFD_REG_RESET   16'h0000
`define TXMFD_MODE_MSB    15
`define TXMFD_MODE_LSB    12
`define TXMFD_LVL_MSB     11
`define TXMFD_LVL_LSB     9
`define TXMFD_GUARD_ON    8
`define TXMFD_GUARD_SEL   7
`define TXMFD_TWIST_MSB   7
`define TXMFD_TWIST_LSB   5
`define TXMFD_SCR_ON      6
`define TXMFD_SCR_DET     5
`define TXMFD_FMT_MSB     4
`define TXMFD_FMT_LSB     3
`define TXMFD_DTMF_BIT    4
`define TXMFD_TONE_LSB    0
`define TXMFD_LEN_MSB     2
`define TXMFD_LEN_LSB     1
`define TXMFD_STOP_BIT    0
`define TXMFD_SRC_BUF     2
`define TXMFD_SRC_LVL     0

// ----------------------------------------------------------------
// Mode codes
// ----------------------------------------------------------------
`define TXMFD_MODE_OFF    4'h0
`define TXMFD_MODE_TONES  4'h1
`define TXMFD_MODE_PSK_LO 4'ha

// ----------------------------------------------------------------
// Character format codes
// ----------------------------------------------------------------
`define TXMFD_FMT_SYNC    2'h3
`define TXMFD_FMT_EVEN    2'h1
`define TXMFD_FMT_ODD     2'h0
`define TXMFD_DBITS_BASE  4'h5

// ----------------------------------------------------------------
// Synchronous data source encodings (output field)
// ----------------------------------------------------------------
`define TXMFD_SRC_BUFFER  2'h0
`define TXMFD_SRC_ONES    2'h1
`define TXMFD_SRC_ZEROS   2'h2
`define TXMFD_SRC_PATTERN 2'h3

// ----------------------------------------------------------------
// Levels in tenths of a dB
// ----------------------------------------------------------------
`define TXMFD_LVL_STEP    8'h0f
`define TXMFD_LVL_TOP     3'h7
`define TXMFD_TW_000      8'h14
`define TXMFD_TW_001      8'h0a
`define TXMFD_TW_010      8'h0f
`define TXMFD_TW_011      8'h19
`define TXMFD_TW_100      8'h1e
`define TXMFD_TW_101      8'h23
`define TXMFD_TW_110      8'h28
`define TXMFD_TW_111      8'h2d

// ----------------------------------------------------------------
// Frequencies in Hz
// ----------------------------------------------------------------
`define TXMFD_HZ_NONE     12'h000
`define TXMFD_HZ_697      12'h2b9
`define TXMFD_HZ_770      12'h302
`define TXMFD_HZ_852      12'h354
`define TXMFD_HZ_941      12'h3ad
`define TXMFD_HZ_1209     12'h4b9
`define TXMFD_HZ_1336     12'h538
`define TXMFD_HZ_1477     12'h5c5
`define TXMFD_HZ_1633     12'h661
`define TXMFD_HZ_1300     12'h514
`define TXMFD_HZ_2100     12'h834
`define TXMFD_HZ_2225     12'h8b1
`define TXMFD_HZ_550      12'h226
`define TXMFD_HZ_1800     12'h708

`endif

// [logic/txmfd_tone_lut.v]
// Tone code to frequency pair lookup for the tones transmit mode
`timescale 1ns/100ps
`include "txmfd_map.vh"

module txmfd_tone_lut (
  // Tone select field, bit 4 picks DTMF
  input  wire [4:0]  tone_code,
  // Decoded result
  output reg  [11:0] low_hz,
  output reg  [11:0] high_hz,
  output reg  [3:0]  pair_sel
);

  // ----------------------------------------------------------------
  // Lookup
  // ----------------------------------------------------------------
  // Pure table; the caller registers the result
  always @* begin
    low_hz   = `TXMFD_HZ_NONE;
    high_hz  = `TXMFD_HZ_NONE;
    pair_sel = 4'h0;
    if (tone_code[`TXMFD_DTMF_BIT]) begin
      // Keypad pair, row on low, column on high
      case (tone_code[3:0])
        4'h0: begin low_hz = `TXMFD_HZ_941; high_hz = `TXMFD_HZ_1633; end
        4'h1: begin low_hz = `TXMFD_HZ_697; high_hz = `TXMFD_HZ_1209; end
        4'h2: begin low_hz = `TXMFD_HZ_697; high_hz = `TXMFD_HZ_1336; end
        4'h3: begin low_hz = `TXMFD_HZ_697; high_hz = `TXMFD_HZ_1477; end
        4'h4: begin low_hz = `TXMFD_HZ_770; high_hz = `TXMFD_HZ_1209; end
        4'h5: begin low_hz = `TXMFD_HZ_770; high_hz = `TXMFD_HZ_1336; end
        4'h6: begin low_hz = `TXMFD_HZ_770; high_hz = `TXMFD_HZ_1477; end
        4'h7: begin low_hz = `TXMFD_HZ_852; high_hz = `TXMFD_HZ_1209; end
        4'h8: begin low_hz = `TXMFD_HZ_852; high_hz = `TXMFD_HZ_1336; end
        4'h9: begin low_hz = `TXMFD_HZ_852; high_hz = `TXMFD_HZ_1477; end
        4'ha: begin low_hz = `TXMFD_HZ_941; high_hz = `TXMFD_HZ_1336; end
        4'hb: begin low_hz = `TXMFD_HZ_941; high_hz = `TXMFD_HZ_1209; end
        4'hc: begin low_hz = `TXMFD_HZ_941; high_hz = `TXMFD_HZ_1477; end
        4'hd: begin low_hz = `TXMFD_HZ_697; high_hz = `TXMFD_HZ_1633; end
        4'he: begin low_hz = `TXMFD_HZ_770; high_hz = `TXMFD_HZ_1633; end
        default: begin
          low_hz  = `TXMFD_HZ_852;
          high_hz = `TXMFD_HZ_1633;
        end
      endcase
    end else begin
      // Single tone on the low output, pairs as one-hot select
      case (tone_code[3:0])
        4'h1:    low_hz = `TXMFD_HZ_697;
        4'h2:    low_hz = `TXMFD_HZ_770;
        4'h3:    low_hz = `TXMFD_HZ_852;
        4'h4:    low_hz = `TXMFD_HZ_941;
        4'h5:    low_hz = `TXMFD_HZ_1209;
        4'h6:    low_hz = `TXMFD_HZ_1336;
        4'h7:    low_hz = `TXMFD_HZ_1477;
        4'h8:    low_hz = `TXMFD_HZ_1633;
        4'h9:    low_hz = `TXMFD_HZ_1300;
        4'ha:    low_hz = `TXMFD_HZ_2100;
        4'hb:    low_hz = `TXMFD_HZ_2225;
        4'hc:    pair_sel = 4'h1;
        4'hd:    pair_sel = 4'h2;
        4'he:    pair_sel = 4'h4;
        4'hf:    pair_sel = 4'h8;
        default: low_hz = `TXMFD_HZ_NONE;
      endcase
    end
  end

endmodule

// [logic/txmfd_top.v]
// Transmit mode register and field decoder
`timescale 1ns/100ps
`include "txmfd_map.vh"

module txmfd_top (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        arst_n,
  // Register write from the serial control interface
  input  wire [15:0] wr_data,
  input  wire        wr_done,
  // Reset sources
  input  wire        gen_reset_cmd,
  input  wire        ctrl_reset_bit,
  // Register image and mode
  output reg  [15:0] mode_reg_r,
  output reg  [3:0]  tx_mode_r,
  output reg         tx_enabled_r,
  output reg         tones_mode_r,
  output reg         psk_mode_r,
  output reg         high_band_r,
  // Level and twist, tenths of a dB, signed
  output reg  [7:0]  level_x10_r,
  output reg  [7:0]  lower_gain_x10_r,
  output reg  [7:0]  upper_gain_x10_r,
  output reg  [7:0]  twist_x10_r,
  // Modem fields
  output reg  [11:0] guard_hz_r,
  output reg         scrambler_en_r,
  output reg         ones64_det_en_r,
  output reg         sync_mode_r,
  output reg         parity_en_r,
  output reg         parity_even_r,
  output reg  [3:0]  data_bits_r,
  output reg  [1:0]  stop_bits_r,
  output reg  [1:0]  sync_src_r,
  output reg         handshake_dibit_pattern_r,
  // Tone generator controls
  output reg  [11:0] tone_low_hz_r,
  output reg  [11:0] tone_high_hz_r,
  output reg         programmed_pair_a_r,
  output reg         programmed_pair_b_r,
  output reg         programmed_pair_c_r,
  output reg         programmed_pair_d_r,
  output reg         tone_start_r
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Gain in tenths of a dB: zero at top code, 15 down per step
  function [7:0] lvl_x10;
    input [2:0] code;
    reg   [7:0] steps;
    begin
      steps   = {5'h00, `TXMFD_LVL_TOP - code};
      lvl_x10 = 8'h00 - steps * `TXMFD_LVL_STEP;
    end
  endfunction

  // Twist code in tenths of a dB; table is not monotonic
  function [7:0] twist_x10;
    input [2:0] code;
    begin
      case (code)
        3'h0:    twist_x10 = `TXMFD_TW_000;
        3'h1:    twist_x10 = `TXMFD_TW_001;
        3'h2:    twist_x10 = `TXMFD_TW_010;
        3'h3:    twist_x10 = `TXMFD_TW_011;
        3'h4:    twist_x10 = `TXMFD_TW_100;
        3'h5:    twist_x10 = `TXMFD_TW_101;
        3'h6:    twist_x10 = `TXMFD_TW_110;
        default: twist_x10 = `TXMFD_TW_111;
      endcase
    end
  endfunction

  // Tone field of a register image, with the DTMF bit
  function [4:0] tone_of;
    input [15:0] img;
    begin
      tone_of = img[`TXMFD_FMT_MSB:`TXMFD_TONE_LSB];
    end
  endfunction

  // Image is in tones mode and sounds something
  function sounding;
    input [15:0] img;
    begin
      sounding = (img[`TXMFD_MODE_MSB:`TXMFD_MODE_LSB] ==
                  `TXMFD_MODE_TONES) &&
                 (tone_of(img) != 5'h00);
    end
  endfunction

  // ----------------------------------------------------------------
  // Register capture
  // ----------------------------------------------------------------
  reg  [15:0] reg_nxt;       // Next register image
  wire        clear_now;     // Either reset source active
  wire        tone_begin;    // A new tone starts with this load

  assign clear_now = gen_reset_cmd | ctrl_reset_bit;

  // Only a finished 16-bit write loads, so fields never mix
  always @* begin
    reg_nxt = mode_reg_r;
    if (clear_now) begin
      reg_nxt = `TXMFD_REG_RESET;
    end else if (wr_done) begin
      reg_nxt = wr_data;
    end
  end

  // Register image; resets beat writes in the same cycle
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg_r <= `TXMFD_REG_RESET;
    end else begin
      mode_reg_r <= reg_nxt;
    end
  end

  // A tone begins when a sounding code differs from what played
  assign tone_begin = sounding(reg_nxt) &&
                      (!sounding(mode_reg_r) ||
                       (tone_of(reg_nxt) != tone_of(mode_reg_r)));

  // ----------------------------------------------------------------
  // Twist hold
  // ----------------------------------------------------------------
  reg  [2:0]  twist_code_r;  // Twist frozen for the running tone

  // Twist is sampled only at the start of a tone, never mid-tone
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      twist_code_r <= 3'h0;
    end else if (clear_now) begin
      twist_code_r <= 3'h0;
    end else if (tone_begin) begin
      twist_code_r <= reg_nxt[`TXMFD_TWIST_MSB:`TXMFD_TWIST_LSB];
    end
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  wire [3:0]  mode_n;        // Mode selector of next image
  wire        tones_n;       // Tones mode
  wire        modem_n;       // Any modem mode
  wire        psk_n;         // QAM or DPSK
  wire        hiband_n;      // Answering band
  wire [1:0]  fmt_n;         // Character format field
  wire [11:0] lut_low;       // Table low or single tone
  wire [11:0] lut_high;      // Table high tone
  wire [3:0]  lut_pair;      // Programmed pair one-hot

  assign mode_n   = reg_nxt[`TXMFD_MODE_MSB:`TXMFD_MODE_LSB];
  assign tones_n  = (mode_n == `TXMFD_MODE_TONES);
  assign modem_n  = (mode_n != `TXMFD_MODE_OFF) && !tones_n;
  assign psk_n    = (mode_n >= `TXMFD_MODE_PSK_LO);
  assign hiband_n = modem_n && reg_nxt[`TXMFD_MODE_LSB];
  assign fmt_n    = reg_nxt[`TXMFD_FMT_MSB:`TXMFD_FMT_LSB];

  // Table shared by fixed tones and keypad pairs
  txmfd_tone_lut u_lut (
    .tone_code (tone_of(reg_nxt)),
    .low_hz    (lut_low),
    .high_hz   (lut_high),
    .pair_sel  (lut_pair)
  );

  // ----------------------------------------------------------------
  // Decoded outputs
  // ----------------------------------------------------------------
  // Registered from the next image, so outputs track the register
  // in the same edge; fields outside the active mode read zero, except sync_src_r, decoded in every mode
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_mode_r                 <= `TXMFD_MODE_OFF;
      tx_enabled_r              <= 1'b0;
      tones_mode_r              <= 1'b0;
      psk_mode_r                <= 1'b0;
      high_band_r               <= 1'b0;
      level_x10_r               <= 8'h00;
      guard_hz_r                <= `TXMFD_HZ_NONE;
      scrambler_en_r            <= 1'b0;
      ones64_det_en_r           <= 1'b0;
      sync_mode_r               <= 1'b0;
      parity_en_r               <= 1'b0;
      parity_even_r             <= 1'b0;
      data_bits_r               <= 4'h0;
      stop_bits_r               <= 2'h0;
      sync_src_r                <= `TXMFD_SRC_BUFFER;
      handshake_dibit_pattern_r <= 1'b0;
      tone_low_hz_r             <= `TXMFD_HZ_NONE;
      tone_high_hz_r            <= `TXMFD_HZ_NONE;
      programmed_pair_a_r       <= 1'b0;
      programmed_pair_b_r       <= 1'b0;
      programmed_pair_c_r       <= 1'b0;
      programmed_pair_d_r       <= 1'b0;
      tone_start_r              <= 1'b0;
    end else begin
      tx_mode_r    <= mode_n;
      tx_enabled_r <= (mode_n != `TXMFD_MODE_OFF);
      tones_mode_r <= tones_n;
      psk_mode_r   <= modem_n && psk_n;
      high_band_r  <= hiband_n;
      tone_start_r <= tone_begin;
      // Level applies in every active mode
      if (mode_n != `TXMFD_MODE_OFF) begin
        level_x10_r <= lvl_x10(
          reg_nxt[`TXMFD_LVL_MSB:`TXMFD_LVL_LSB]);
      end else begin
        level_x10_r <= 8'h00;
      end
      // Guard tone only with high-band QAM or DPSK
      if (hiband_n && psk_n && reg_nxt[`TXMFD_GUARD_ON]) begin
        guard_hz_r <= reg_nxt[`TXMFD_GUARD_SEL] ?
                      `TXMFD_HZ_550 : `TXMFD_HZ_1800;
      end else begin
        guard_hz_r <= `TXMFD_HZ_NONE;
      end
      // Scrambler and its long-ones detector
      scrambler_en_r  <= modem_n && psk_n &&
                         reg_nxt[`TXMFD_SCR_ON];
      ones64_det_en_r <= modem_n && psk_n && reg_nxt[`TXMFD_SCR_ON] &&
                         reg_nxt[`TXMFD_SCR_DET];
      // Character format
      sync_mode_r   <= modem_n && (fmt_n == `TXMFD_FMT_SYNC);
      parity_en_r   <= modem_n && ((fmt_n == `TXMFD_FMT_EVEN) ||
                                   (fmt_n == `TXMFD_FMT_ODD));
      parity_even_r <= modem_n && (fmt_n == `TXMFD_FMT_EVEN);
      // Start-stop lengths, zero when not in start-stop
      if (modem_n && (fmt_n != `TXMFD_FMT_SYNC)) begin
        data_bits_r <= `TXMFD_DBITS_BASE +
          {2'h0, reg_nxt[`TXMFD_LEN_MSB:`TXMFD_LEN_LSB]};
        stop_bits_r <= reg_nxt[`TXMFD_STOP_BIT] ? 2'h2 : 2'h1;
      end else begin
        data_bits_r <= 4'h0;
        stop_bits_r <= 2'h0;
      end
      // Synchronous data source
      handshake_dibit_pattern_r <= 1'b0;
      if (reg_nxt[`TXMFD_SRC_BUF]) begin
        sync_src_r <= `TXMFD_SRC_BUFFER;
      end else if (reg_nxt[`TXMFD_LEN_LSB]) begin
        sync_src_r <= reg_nxt[`TXMFD_SRC_LVL] ?
                      `TXMFD_SRC_ONES : `TXMFD_SRC_ZEROS;
      end else begin
        sync_src_r <= `TXMFD_SRC_PATTERN;
        // Dibit pattern in PSK, alternating bits elsewhere
        handshake_dibit_pattern_r <= modem_n && psk_n &&
                                     (fmt_n == `TXMFD_FMT_SYNC);
      end
      // Tone generator, silent outside tones mode
      if (tones_n) begin
        tone_low_hz_r       <= lut_low;
        tone_high_hz_r      <= lut_high;
        programmed_pair_a_r <= lut_pair[0];
        programmed_pair_b_r <= lut_pair[1];
        programmed_pair_c_r <= lut_pair[2];
        programmed_pair_d_r <= lut_pair[3];
      end else begin
        tone_low_hz_r       <= `TXMFD_HZ_NONE;
        tone_high_hz_r      <= `TXMFD_HZ_NONE;
        programmed_pair_a_r <= 1'b0;
        programmed_pair_b_r <= 1'b0;
        programmed_pair_c_r <= 1'b0;
        programmed_pair_d_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Tone group gains
  // ----------------------------------------------------------------
  // Lower group never sees twist; upper group adds the held value.
  // Limitation: max twist with 0 dB level overdrives the line, and
  // the host is expected not to pick that pair.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      twist_x10_r      <= 8'h00;
      lower_gain_x10_r <= 8'h00;
      upper_gain_x10_r <= 8'h00;
    end else if (tones_n && !clear_now) begin
      twist_x10_r      <= twist_x10(tone_begin ?
        reg_nxt[`TXMFD_TWIST_MSB:`TXMFD_TWIST_LSB] :
        twist_code_r);
      lower_gain_x10_r <= lvl_x10(
        reg_nxt[`TXMFD_LVL_MSB:`TXMFD_LVL_LSB]);
      upper_gain_x10_r <= lvl_x10(
        reg_nxt[`TXMFD_LVL_MSB:`TXMFD_LVL_LSB]) +
        twist_x10(tone_begin ?
        reg_nxt[`TXMFD_TWIST_MSB:`TXMFD_TWIST_LSB] :
        twist_code_r);
    end else begin
      twist_x10_r      <= 8'h00;
      lower_gain_x10_r <= 8'h00;
      upper_gain_x10_r <= 8'h00;
    end
  end

endmodule

// [testbench/txmfd_checker.sv]
// Port-level assertions for the transmit mode field decoder
`timescale 1ns/100ps
module txmfd_checker (
  // Clock and reset
  input logic        sys_clk,
  input logic        arst_n,
  // Write side and reset sources
  input logic [15:0] wr_data,
  input logic        wr_done,
  input logic        gen_reset_cmd,
  input logic        ctrl_reset_bit,
  // Decoded outputs
  input logic [15:0] mode_reg_r,
  input logic [3:0]  tx_mode_r,
  input logic        tx_enabled_r,
  input logic        tones_mode_r,
  input logic [7:0]  level_x10_r,
  input logic [7:0]  lower_gain_x10_r,
  input logic [7:0]  upper_gain_x10_r,
  input logic [7:0]  twist_x10_r,
  input logic [11:0] guard_hz_r,
  input logic        scrambler_en_r,
  input logic        ones64_det_en_r,
  input logic        sync_mode_r,
  input logic [3:0]  data_bits_r,
  input logic        tone_start_r
);
  // Twist in tenths of a dB, code 000 in the top byte
  localparam logic [63:0] twist_tab = 64'h140a_0f19_1e23_282d;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------------------------------
  // Register image
  // ----------------------------------------------------------------
  a_write_applies: assert property (
    wr_done && !gen_reset_cmd && !ctrl_reset_bit
    |=> mode_reg_r == $past(wr_data)) else $error("image not loaded");
  a_idle_holds: assert property (
    !wr_done && !gen_reset_cmd && !ctrl_reset_bit
    |=> $stable(mode_reg_r) && $stable(level_x10_r))
    else $error("image moved without write");
  a_reset_clears: assert property (
    gen_reset_cmd || ctrl_reset_bit |=> mode_reg_r == 16'h0000
    && !tx_enabled_r && guard_hz_r == 12'h000) else $error("not cleared");
  a_mode_decode: assert property (tx_mode_r == mode_reg_r[15:12]
    && tx_enabled_r == (tx_mode_r != 4'h0)
    && tones_mode_r == (tx_mode_r == 4'h1)) else $error("mode decode");
  // ----------------------------------------------------------------
  // Level, twist and tones
  // ----------------------------------------------------------------
  a_level_steps: assert property (level_x10_r == (tx_enabled_r ?
    {5'h00, mode_reg_r[11:9]} * 8'h0f - 8'h69 : 8'h00))
    else $error("level step");
  a_upper_only: assert property (tones_mode_r |->
    lower_gain_x10_r == level_x10_r
    && upper_gain_x10_r == level_x10_r + twist_x10_r)
    else $error("twist on wrong group");
  a_twist_latch: assert property (
    tones_mode_r && $past(tones_mode_r) && !$stable(twist_x10_r)
    |-> tone_start_r) else $error("twist changed mid-tone");
  a_twist_code: assert property (tone_start_r |->
    twist_x10_r == twist_tab[63 - 8 * mode_reg_r[7:5] -: 8])
    else $error("twist code");
  a_tone_start: assert property (tone_start_r |-> tones_mode_r
    && mode_reg_r[4:0] != 5'h00) else $error("start without tone");
  // ----------------------------------------------------------------
  // Modem fields
  // ----------------------------------------------------------------
  a_guard_tone: assert property (guard_hz_r ==
    ((tx_mode_r >= 4'ha && tx_mode_r[0] && mode_reg_r[8]) ?
    (mode_reg_r[7] ? 12'h226 : 12'h708) : 12'h000)) else $error("guard");
  a_scrambler_bits: assert property (
    scrambler_en_r == (tx_mode_r >= 4'ha && mode_reg_r[6])
    && ones64_det_en_r == (scrambler_en_r && mode_reg_r[5]))
    else $error("scrambler");
  a_sync_format: assert property (sync_mode_r ==
    (tx_mode_r >= 4'h2 && mode_reg_r[4:3] == 2'h3)) else $error("format");
  a_data_length: assert property (data_bits_r ==
    ((tx_mode_r >= 4'h2 && !sync_mode_r) ? 4'h5 + mode_reg_r[2:1] : 4'h0))
    else $error("data length");
endmodule
bind txmfd_top txmfd_checker chk_u (.*);

// [testbench/txmfd_host.sv]
// Host controller model that writes the transmit mode register
`timescale 1ns/100ps
module txmfd_host (
  // Clock
  input  logic        sys_clk,
  // Register write and reset sources
  output logic [15:0] wr_data,
  output logic        wr_done,
  output logic        gen_reset_cmd,
  output logic        ctrl_reset_bit
);
  int gap = 0;  // Idle cycles before a write, for a slow host
  initial begin
    wr_data = 16'h0000;
    wr_done = 1'b0;
    gen_reset_cmd = 1'b0;
    ctrl_reset_bit = 1'b0;
  end
  // One whole word; keep leaves the strobe up for a back-to-back write
  task automatic write_reg(input logic [15:0] d, input logic keep,
                           input logic gen = 1'b0);
    logic [15:0] v;
    v = d;
    if (v[15:12] == 4'h1) begin
      v[8] = 1'b0;
      if (v[11:9] == 3'h7 && v[7:5] == 3'h7)
        v[5] = 1'b0;
    end
    if (wr_done !== 1'b1) begin
      repeat (gap) @(posedge sys_clk);
      @(posedge sys_clk);
      #1;
    end
    wr_data = v;
    wr_done = 1'b1;
    gen_reset_cmd = gen;
    @(posedge sys_clk);
    #1;
    if (gen)
      gen_reset_cmd = 1'b0;
    if (!keep) begin
      wr_done = 1'b0;
      wr_data = ~v;  // Stale data must not look valid
    end
  endtask
  // Control reset bit, a level
  task automatic hold_ctrl(input logic b);
    @(posedge sys_clk);
    #1;
    ctrl_reset_bit = b;
  endtask
endmodule

// [testbench/tb.sv]
// Self-checking bench for the transmit mode field decoder
`timescale 1ns/100ps
module tb;
  // One modem write and the fields it should give
  typedef struct packed {
    logic [15:0] w;
    logic [11:0] g;
    logic [5:0]  f;  // scr, det, sync, par_en, even, dibit
    logic [3:0]  db;
    logic [1:0]  sb;
    logic [1:0]  src;
  } txmfd_row_t;
  localparam txmfd_row_t rows [8] = '{
    '{16'hfff9, 12'h226, 6'h39, 4'h0, 2'h0, 2'h3},
    '{16'hdd57, 12'h708, 6'h20, 4'h8, 2'h2, 2'h0},
    '{16'hcbaa, 12'h000, 6'h06, 4'h6, 2'h1, 2'h2},
    '{16'h9201, 12'h000, 6'h04, 4'h5, 2'h2, 2'h3},
    '{16'hb8fb, 12'h000, 6'h38, 4'h0, 2'h0, 2'h1},
    '{16'h2614, 12'h000, 6'h00, 4'h7, 2'h1, 2'h0},
    '{16'h4000, 12'h000, 6'h04, 4'h5, 2'h1, 2'h3},
    '{16'h0000, 12'h000, 6'h00, 4'h0, 2'h0, 2'h3}};
  // Tone frequencies in Hz, and keypad rows and columns as indices
  localparam logic [11:0] hz [12] = '{12'h000, 12'h2b9, 12'h302, 12'h354,
    12'h3ad, 12'h4b9, 12'h538, 12'h5c5, 12'h661, 12'h514, 12'h834, 12'h8b1};
  localparam logic [63:0] dlo = 64'h4111_2223_3344_4123;
  localparam logic [63:0] dhi = 64'h8567_5675_6765_7888;
  localparam logic [63:0] twist_tab = 64'h140a_0f19_1e23_282d;
  logic        sys_clk, arst_n, wr_done, gen_reset_cmd, ctrl_reset_bit;
  logic [15:0] wr_data, mode_reg_r;
  logic [3:0]  tx_mode_r, data_bits_r, pr;
  logic        tx_enabled_r, tones_mode_r, psk_mode_r, high_band_r;
  logic [7:0]  level_x10_r, lower_gain_x10_r, upper_gain_x10_r;
  logic [7:0]  twist_x10_r, tw;
  logic [11:0] guard_hz_r, tone_low_hz_r, tone_high_hz_r, lo, hi;
  logic        scrambler_en_r, ones64_det_en_r, sync_mode_r, parity_en_r;
  logic        parity_even_r, handshake_dibit_pattern_r, tone_start_r;
  logic        programmed_pair_a_r, programmed_pair_b_r;
  logic        programmed_pair_c_r, programmed_pair_d_r;
  logic [1:0]  stop_bits_r, sync_src_r;
  txmfd_row_t  r;
  int          errors = 0;
  int          num_checks = 0;
  txmfd_host host_u (.*);
  txmfd_top dut_u (.*);
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Gain in tenths of a dB, zero while the transmitter is off
  function automatic logic [7:0] lvl(input logic [15:0] w);
    return (w[15:12] == 4'h0) ? 8'h00 : {5'h00, w[11:9]} * 8'h0f - 8'h69;
  endfunction
  // Hang guard
  initial begin
    repeat (5000) @(posedge sys_clk);
    errors++;
    $display("unexpected at %0t: run stalled", $time);
    print_verdict();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    repeat (10) @(posedge sys_clk);
    #1;
    arst_n = 1'b1;
    chk(mode_reg_r, 16'h0000, "reset image");
    foreach (rows[i]) begin
      r = rows[i];
      host_u.write_reg(r.w, 1'b0);
      chk(mode_reg_r, r.w, "image");
      chk({tx_mode_r, psk_mode_r, high_band_r}, {r.w[15:12],
        r.w[15:12] >= 4'ha, r.w[15:12] > 4'h1 && r.w[12]}, "mode");
      chk(level_x10_r, lvl(r.w), "level");
      chk(guard_hz_r, r.g, "guard");
      chk({scrambler_en_r, ones64_det_en_r}, r.f[5:4], "scr");
      chk({sync_mode_r, parity_en_r, parity_even_r}, r.f[3:1], "fmt");
      chk({data_bits_r, stop_bits_r}, {r.db, r.sb}, "length");
      chk({sync_src_r, handshake_dibit_pattern_r}, {r.src, r.f[0]}, "src");
    end
    // Every tone and keypad code, level 0 dB
    for (int c = 0; c < 32; c++) begin
      host_u.write_reg({11'h0f0, c[4:0]}, 1'b0);
      lo = (c < 12) ? hz[c] : 12'h000;
      hi = 12'h000;
      pr = 4'h0;
      if (c >= 16) begin
        lo = hz[dlo[63 - 4 * (c - 16) -: 4]];
        hi = hz[dhi[63 - 4 * (c - 16) -: 4]];
      end else if (c >= 12)
        pr = 4'h8 >> (c - 12);
      chk({tone_low_hz_r, tone_high_hz_r}, {lo, hi}, "tone");
      chk({programmed_pair_a_r, programmed_pair_b_r, programmed_pair_c_r,
           programmed_pair_d_r}, pr, "pair");
      chk(tone_start_r, c != 0, "start");
    end
    // Every twist code on a fresh key, slow host
    host_u.gap = 2;
    for (int t = 0; t < 8; t++) begin
      host_u.write_reg({8'h14, t[2:0], 5'h11 + t[4:0]}, 1'b0);
      tw = twist_tab[63 - 8 * t -: 8];
      chk({lower_gain_x10_r, upper_gain_x10_r, twist_x10_r},
          {8'hb5, 8'hb5 + tw, tw}, "twist");
    end
    host_u.gap = 0;
    // Same key keeps the old twist, a new key takes the new one
    host_u.write_reg(16'h1438, 1'b0);
    chk({twist_x10_r, tone_start_r}, {8'h2d, 1'b0}, "held");
    host_u.write_reg(16'h1432, 1'b0);
    chk({twist_x10_r, tone_start_r}, {8'h0a, 1'b1}, "new");
    host_u.write_reg(16'h1ef5, 1'b0);
    chk(twist_x10_r, 8'h28, "twist capped");
    // Back-to-back writes
    host_u.write_reg(16'h1e11, 1'b1);
    chk(mode_reg_r, 16'h1e11, "first");
    host_u.write_reg(16'hdd57, 1'b0);
    chk({mode_reg_r, guard_hz_r}, {16'hdd57, 12'h708}, "second");
    // Reset command beats a write; control bit refuses writes
    host_u.write_reg(16'h1e15, 1'b0, 1'b1);
    chk({mode_reg_r, level_x10_r, twist_x10_r}, 32'h0, "gen");
    host_u.write_reg(16'h1e15, 1'b0);
    host_u.hold_ctrl(1'b1);
    host_u.write_reg(16'hb8fb, 1'b0);
    chk({mode_reg_r, tone_low_hz_r}, 28'h0, "ctrl");
    host_u.hold_ctrl(1'b0);
    // Asynchronous reset in mid-run
    host_u.write_reg(16'h1e15, 1'b0);
    arst_n = 1'b0;
    #2;
    chk({mode_reg_r, tone_start_r}, 17'h0, "async");
    repeat (2) @(posedge sys_clk);
    #1;
    arst_n = 1'b1;
    host_u.write_reg(16'h1e15, 1'b0);
    chk({twist_x10_r, tone_start_r}, {8'h14, 1'b1}, "restart");
    print_verdict();
  end
endmodule
